/* lrc_pkg.sv */
// constants, register map and carrier types of the link error-rate counters
package lrc_pkg;
    localparam int          CLK_PERIOD_NS = 5;
    localparam int          TICK_TIME_NS  = 1000;
    localparam int          TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int          TICK_CNT_W    = $clog2(TICK_CYCLES);
    localparam logic [TICK_CNT_W-1:0] TICK_LAST =
        TICK_CNT_W'(TICK_CYCLES - 1);

    localparam int          ADDR_W        = 12;
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 12'h560;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 12'h564;
    localparam logic [ADDR_W-1:0] OFS_THRESH   = 12'h568;
    localparam logic [ADDR_W-1:0] OFS_COUNT    = 12'h56c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h570;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h574;

    localparam int          ERR_W         = 8;
    localparam int          WIN_W         = 24;
    localparam int          IRQ_W         = 2;
    localparam logic [ERR_W-1:0] ERR_MAX     = 8'hff;
    localparam logic [WIN_W-1:0] WIN_MAX     = 24'hff_ffff;
    localparam logic [ERR_W-1:0] THR_RESET   = 8'hff;
    localparam logic [WIN_W-1:0] PERIOD_RESET = 24'hff_ffff;
    localparam logic        TYPE_CRC      = 1'h0;
    localparam logic        TYPE_RECOVERY = 1'h1;
    localparam int          IRQ_UNRELIABLE = 0;
    localparam int          IRQ_WINDOW     = 1;

    typedef struct packed {
        logic             error_type;
        logic             enable;
    } lrc_ctrl_t;

    typedef struct packed {
        logic [WIN_W-1:0] window_elapsed_us;
        logic [ERR_W-1:0] error_tally;
    } lrc_count_t;

    typedef struct packed {
        logic [WIN_W-1:0] period;
        logic [ERR_W-1:0] error_threshold;
    } lrc_thresh_t;
endpackage

/* lrc_counters.sv */
// link reliability monitor: error and window counters with apb registers
//
// Notes on behaviour
// RULE_01: error tally counts errors, saturates at max
// RULE_02: window count twenty-four bits, saturates at max
// RULE_03: window count advances once per microsecond
// RULE_04: retrain request or detect clears error tally
// RULE_05: retrain request or detect clears window
// RULE_06: enable rising edge clears both counts
// RULE_07: unreliable link freezes both counts
// RULE_08: window equals period restarts error tally
// RULE_09: window equals period restarts window count
// RULE_10: counts run even while monitoring disabled
// RULE_11: sticky write-one-clear flag when tally reaches threshold
// RULE_12: error type selects crc or recovery events
// RULE_13: threshold and period registers with full defaults
// RULE_14: enable bit turns monitoring on and off
// RULE_15: divider makes one-cycle microsecond tick
// RULE_16: one error counted per cycle at most
`timescale 1ns/1ps
`default_nettype none
module lrc_counters
    import lrc_pkg::*;
(
    // clock and reset
    input  wire logic              CORE_CLK,
    input  wire logic              RESET,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic [31:0]            PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // link events
    input  wire logic              LINK_RETRAIN_REQUEST,
    input  wire logic              LINK_IN_DETECT,
    input  wire logic              CRC_ERROR_PULSE,
    input  wire logic              RECOVERY_ENTRY_PULSE,
    // interrupt
    output logic                   IRQ
);

    lrc_ctrl_t                ctrl_q, ctrl_d;
    logic                     enable_prev_q;
    logic                     flag_q, flag_d;
    lrc_thresh_t              thr_q, thr_d;
    lrc_count_t               cnt_q, cnt_d;
    logic [IRQ_W-1:0]         istat_q, istat_d;
    logic [IRQ_W-1:0]         imask_q, imask_d;
    logic [31:0]              rdata_q, rdata_d;
    logic [TICK_CNT_W-1:0]    div_q, div_d;
    logic                     tick;
    logic                     clear_all;
    logic                     win_hit;
    logic                     err_event;
    logic                     setup;
    logic                     wr_acc;
    logic                     rd_acc;
    logic                     mapped;
    logic [IRQ_W-1:0]         events;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a == OFS_CTRL || a == OFS_STATUS || a == OFS_THRESH ||
               a == OFS_COUNT || a == OFS_IRQ_STAT || a == OFS_IRQ_MASK;
    endfunction

    function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a);
        logic [31:0] v;
        v = '0;
        unique case (a)
            OFS_CTRL:     v = {30'h0, ctrl_q};
            OFS_STATUS:   v = {31'h0, flag_q};
            OFS_THRESH:   v = thr_q;
            OFS_COUNT:    v = cnt_q;
            OFS_IRQ_STAT: v = {30'h0, istat_q};
            OFS_IRQ_MASK: v = {30'h0, imask_q};
            default:      v = '0;
        endcase
        return v;
    endfunction

    // bus decode; zero wait states
    assign mapped  = is_mapped(PADDR);
    assign setup   = PSEL && !PENABLE;
    assign wr_acc  = PSEL && PENABLE && PWRITE && mapped;
    assign rd_acc  = PSEL && PENABLE && !PWRITE && mapped;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA  = rdata_q;
    assign IRQ     = |(istat_q & imask_q);

    // microsecond divider
    always_comb begin
        div_d = (div_q == TICK_LAST) ? '0 : div_q + 1'b1; // RULE_15
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end
    assign tick = (div_q == TICK_LAST); // RULE_15 RULE_03

    // event select, at most one per cycle
    assign err_event = (ctrl_q.error_type == TYPE_RECOVERY) ?
                       RECOVERY_ENTRY_PULSE : CRC_ERROR_PULSE; // RULE_12 RULE_16
    assign clear_all = LINK_RETRAIN_REQUEST || LINK_IN_DETECT ||
                       (ctrl_q.enable && !enable_prev_q); // RULE_04 RULE_05 RULE_06
    assign win_hit   = (cnt_q.window_elapsed_us == thr_q.period);

    // counters
    always_comb begin
        cnt_d = cnt_q;
        if (clear_all) begin
            cnt_d = '0; // RULE_04 RULE_05 RULE_06
        end else if (flag_q) begin
            cnt_d = cnt_q; // RULE_07
        end else if (win_hit) begin
            cnt_d = '0; // RULE_08 RULE_09
        end else begin
            // counting does not look at the enable bit
            if (err_event && cnt_q.error_tally != ERR_MAX) begin
                cnt_d.error_tally = cnt_q.error_tally + 1'b1; // RULE_01 RULE_10
            end
            if (tick && cnt_q.window_elapsed_us != WIN_MAX) begin
                cnt_d.window_elapsed_us =
                    cnt_q.window_elapsed_us + 1'b1; // RULE_02 RULE_03
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // unreliable flag, set beats write-one clear
    always_comb begin
        flag_d = flag_q;
        if (wr_acc && PADDR == OFS_STATUS && PWDATA[0]) begin
            flag_d = 1'b0;
        end
        if (ctrl_q.enable &&
            cnt_q.error_tally >= thr_q.error_threshold) begin
            flag_d = 1'b1; // RULE_11
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // control, threshold and mask writes
    always_comb begin
        ctrl_d  = ctrl_q;
        thr_d   = thr_q;
        imask_d = imask_q;
        if (wr_acc) begin
            unique case (PADDR)
                OFS_CTRL:     ctrl_d  = lrc_ctrl_t'(PWDATA[1:0]); // RULE_14
                OFS_THRESH:   thr_d   = PWDATA; // RULE_13
                OFS_IRQ_MASK: imask_d = PWDATA[IRQ_W-1:0];
                default:      ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_q        <= '0;
            enable_prev_q <= 1'b0;
            thr_q         <= '{period: PERIOD_RESET,
                               error_threshold: THR_RESET}; // RULE_13
            imask_q       <= '0;
        end else begin
            ctrl_q        <= ctrl_d;
            enable_prev_q <= ctrl_q.enable; // RULE_06
            thr_q         <= thr_d;
            imask_q       <= imask_d;
        end
    end

    // interrupt status, read clears only what the read returned
    always_comb begin
        events = '0;
        events[IRQ_UNRELIABLE] = flag_d && !flag_q;
        events[IRQ_WINDOW]     = win_hit && !clear_all && !flag_q;
        istat_d = istat_q;
        if (rd_acc && PADDR == OFS_IRQ_STAT) begin
            istat_d = istat_q & ~rdata_q[IRQ_W-1:0];
        end
        istat_d = istat_d | events;
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            istat_q <= '0;
        end else begin
            istat_q <= istat_d;
        end
    end

    // read data latched in the setup cycle
    always_comb begin
        rdata_d = rdata_q;
        if (setup) begin
            rdata_d = (!PWRITE) ? read_mux(PADDR) : '0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    sequence s_free;
        !clear_all && !flag_q && !win_hit;
    endsequence

    sequence s_tick_gap;
        !tick [*8];
    endsequence

    AST_ERR_SAT: assert property ( // RULE_01
        s_free and (cnt_q.error_tally == ERR_MAX)
        |=> cnt_q.error_tally == ERR_MAX)
        else $error("error tally left its maximum");

    AST_ERR_INC: assert property ( // RULE_16
        s_free and (err_event && cnt_q.error_tally != ERR_MAX)
        |=> cnt_q.error_tally == $past(cnt_q.error_tally) + 8'h01)
        else $error("error tally did not advance by one");

    AST_ERR_HOLD: assert property ( // RULE_12
        s_free and (!err_event)
        |=> $stable(cnt_q.error_tally))
        else $error("error tally moved without a selected event");

    AST_WIN_TICK: assert property ( // RULE_03
        s_free and (!tick) |=> $stable(cnt_q.window_elapsed_us))
        else $error("window advanced without a tick");

    AST_TICK_GAP: assert property ( // RULE_15
        tick |=> s_tick_gap ##192 tick)
        else $error("microsecond tick spacing wrong");

    AST_CLEAR: assert property ( // RULE_04
        (LINK_RETRAIN_REQUEST || LINK_IN_DETECT) |=> cnt_q == '0)
        else $error("counts not cleared by retrain or detect");

    AST_EN_RISE: assert property ( // RULE_06
        $rose(ctrl_q.enable) |=> cnt_q == '0)
        else $error("counts not cleared on enable rise");

    AST_FREEZE: assert property ( // RULE_07
        (flag_q && !clear_all) |=> $stable(cnt_q))
        else $error("counts moved while link unreliable");

    AST_RESTART: assert property ( // RULE_08 RULE_09
        (win_hit && !flag_q && !clear_all) |=> cnt_q == '0)
        else $error("counts not restarted at period");

    AST_FLAG_SET: assert property ( // RULE_11
        (ctrl_q.enable && cnt_q.error_tally >= thr_q.error_threshold)
        |=> flag_q)
        else $error("unreliable flag not set");

    AST_FLAG_STICKY: assert property ( // RULE_11
        (flag_q && !(wr_acc && PADDR == OFS_STATUS && PWDATA[0]))
        |=> flag_q)
        else $error("unreliable flag cleared without software");

    AST_FLAG_W1C: assert property ( // RULE_11
        (wr_acc && PADDR == OFS_STATUS && PWDATA[0] &&
         !(ctrl_q.enable && cnt_q.error_tally >= thr_q.error_threshold))
        |=> !flag_q)
        else $error("write of one did not clear the unreliable flag");

    AST_FLAG_IRQ: assert property ( // RULE_11
        (flag_d && !flag_q) |=> istat_q[IRQ_UNRELIABLE])
        else $error("flag rise did not raise its interrupt status");

    AST_FLAG_EN: assert property ( // RULE_14
        (!ctrl_q.enable && !flag_q) |=> !flag_q)
        else $error("flag set while monitoring disabled");

endmodule
`default_nettype wire

/* lrc_counters_tb.sv */
// self-checking testbench of the link error-rate counters
`timescale 1ns/1ps
`default_nettype none
module lrc_counters_tb
    import lrc_pkg::*;
;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        psel = 1'b0;
    logic        pen  = 1'b0;
    logic        pwr  = 1'b0;
    logic [11:0] pa   = 12'h000;
    logic [31:0] pwd  = 32'h0000_0000;
    logic        crc  = 1'b0;
    logic        rec  = 1'b0;
    logic        ret  = 1'b0;
    logic        det  = 1'b0;
    logic [31:0] prd;
    logic        prdy;
    logic        perr;
    logic        irq;
    logic [31:0] rd;
    logic        se;
    logic [31:0] t;
    int          n_errors = 0;
    int          checked  = 0;

    always #2.5 clk = ~clk;

    lrc_counters dut_u (
        .CORE_CLK             (clk),
        .RESET                (rst),
        .PSEL                 (psel),
        .PENABLE              (pen),
        .PWRITE               (pwr),
        .PADDR                (pa),
        .PWDATA               (pwd),
        .PRDATA               (prd),
        .PREADY               (prdy),
        .PSLVERR              (perr),
        .LINK_RETRAIN_REQUEST (ret),
        .LINK_IN_DETECT       (det),
        .CRC_ERROR_PULSE      (crc),
        .RECOVERY_ENTRY_PULSE (rec),
        .IRQ                  (irq)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one apb transfer; read data and error land in rd and se
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen  <= 1'b0;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        rd = prd;
        se = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic hit(input logic c, input logic r, input int n);
        repeat (n) begin
            @(posedge clk);
            crc <= c;
            rec <= r;
        end
        @(posedge clk);
        crc <= 1'b0;
        rec <= 1'b0;
    endtask

    // d=0 retrain request, d=1 detect, one cycle
    task automatic clr(input logic d);
        @(posedge clk);
        ret <= ~d;
        det <= d;
        @(posedge clk);
        ret <= 1'b0;
        det <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic t_reset;
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, OFS_THRESH, 32'h0);
        check(rd, 32'hffff_ffff);
        apb(1'b1, OFS_COUNT, 32'hffff_ffff);
        apb(1'b0, OFS_COUNT, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h500, 32'h0);
        check({31'h0, se}, 32'h1);
    endtask

    task automatic t_count;
        clr(1'b0);
        hit(1'b1, 1'b0, 300);
        hit(1'b0, 1'b1, 5);
        idle(1700);
        apb(1'b0, OFS_COUNT, 32'h0);
        check({24'h0, rd[7:0]}, 32'hff);
        check({31'h0, rd[31:8] inside {24'd10, 24'd11}}, 32'h1);
    endtask

    task automatic t_type;
        apb(1'b1, OFS_CTRL, 32'h2);
        clr(1'b0);
        hit(1'b1, 1'b0, 3);
        hit(1'b0, 1'b1, 2);
        idle(2);
        apb(1'b0, OFS_COUNT, 32'h0);
        check({24'h0, rd[7:0]}, 32'h2);
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, OFS_CTRL, 32'h0);
    endtask

    task automatic t_period;
        apb(1'b1, OFS_THRESH, {24'h3, 8'hff});
        apb(1'b1, OFS_IRQ_MASK, 32'h2);
        clr(1'b0);
        hit(1'b1, 1'b0, 5);
        idle(1000);
        apb(1'b0, OFS_COUNT, 32'h0);
        check({24'h0, rd[7:0]}, 32'h0);
        check({31'h0, rd[31:8] <= 24'h3}, 32'h1);
        check({31'h0, irq}, 32'h1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        check(rd & 32'h2, 32'h2);
        idle(1);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
    endtask

    task automatic t_flag;
        apb(1'b1, OFS_THRESH, {24'hff_ffff, 8'h02});
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h1);
        idle(3);
        hit(1'b1, 1'b0, 2);
        idle(3);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd, 32'h1);
        check({31'h0, irq}, 32'h1);
        apb(1'b0, OFS_COUNT, 32'h0);
        t = rd;
        hit(1'b1, 1'b0, 3);
        idle(400);
        apb(1'b0, OFS_COUNT, 32'h0);
        check(rd, t);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        check(rd & 32'h1, 32'h1);
        idle(1);
        check({31'h0, irq}, 32'h0);
        clr(1'b0);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, OFS_STATUS, 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd, 32'h0);
    endtask

    // each clear starts from tally 1 and window of at least 2
    task automatic t_clear;
        hit(1'b1, 1'b0, 1);
        idle(450);
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1);
        idle(3);
        apb(1'b0, OFS_COUNT, 32'h0);
        check({24'h0, rd[7:0]}, 32'h0);
        check({31'h0, rd[31:8] <= 24'h1}, 32'h1);
        hit(1'b1, 1'b0, 1);
        idle(450);
        clr(1'b1);
        idle(1);
        apb(1'b0, OFS_COUNT, 32'h0);
        check({24'h0, rd[7:0]}, 32'h0);
        check({31'h0, rd[31:8] <= 24'h1}, 32'h1);
        hit(1'b1, 1'b0, 1);
        idle(450);
        clr(1'b0);
        idle(1);
        apb(1'b0, OFS_COUNT, 32'h0);
        check({24'h0, rd[7:0]}, 32'h0);
        check({31'h0, rd[31:8] <= 24'h1}, 32'h1);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_count;
        t_type;
        t_period;
        t_flag;
        t_clear;
        finish_test;
    end

    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        finish_test;
    end
endmodule
`default_nettype wire
